/* core/flash_self_program_control.v */
// Purpose: Self-programming control for on-chip program flash.
// Assumes: CPU-side strobes, pointer, data and fuses come from the same clock.
// Notes:   The clock enable also freezes the bus slave.
//
// Notes on behaviour
// - Two-bit size select gives 4, 8, 16 or 32 boot pages at flash top.
// - Bottom 224 pages are live-readable, top 32 pages form the stalling section.
// - Pointer bits above bit zero give word in page, higher bits give page.
// - Ready interrupt requested while enabled, globally enabled and store enable low.
// - Erase or write to live section sets busy flag, which blocks that section.
// - Busy flag clears by re-enable after completion, or by a buffer fill.
// - Read enable with store enable arms a re-enable for four cycles.
// - Writing read enable during buffer loading discards the buffer contents.
// - Lock write arms for four cycles, takes low data only, clears when done.
// - Load within three cycles of lock arming returns lock or fuse byte.
// - Page write arms for four cycles, programs pointer page from the buffer.
// - Page erase arms for four cycles, erases the pointer page.
// - Erase or write to the stalling section stalls the CPU throughout.
// - Store enable alone arms a fill of one buffer word from both data bytes.
// - Store enable clears after a store or four idle cycles, held during operations.
// - Only listed low five-bit combinations are accepted; others arm nothing.
// - Pointer 0 fuse low, 1 lock bits, 2 extended fuse, 3 fuse high.
// - Programmed fuse and lock bits read as zero, unprogrammed as one.
// - Erase, page write and lock write each last between 3.7 ms and 4.5 ms.
// - A data EEPROM write blocks flash programming and fuse or lock reads.
`timescale 1ns/1ps
`include "flash_spm_consts.vh"
module flash_self_program_control #(
    parameter ADDR_W      = 14,
    parameter PAGE_W      = 6,
    parameter CNT_W       = 16,
    parameter PROG_CYCLES = `PROG_MIN_CYCLES
) (
    // Clock, reset and enable
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire                     ce_i,
    // Wishbone slave
    input  wire                     wb_cyc_i,
    input  wire                     wb_stb_i,
    input  wire                     wb_we_i,
    input  wire [3:0]               wb_adr_i,
    input  wire [3:0]               wb_sel_i,
    input  wire [31:0]              wb_dat_i,
    output reg  [31:0]              wb_dat_o,
    output reg                      wb_ack_o,
    // CPU instruction side
    input  wire                     spm_exec_i,
    input  wire                     lpm_exec_i,
    input  wire [15:0]              pointer_i,
    input  wire [7:0]               low_data_reg_i,
    input  wire [7:0]               high_data_reg_i,
    input  wire                     global_irq_enable_i,
    input  wire                     eeprom_busy_i,
    // Fuses, one marks a programmed bit
    input  wire [1:0]               boot_size_select_i,
    input  wire [7:0]               fuse_low_i,
    input  wire [7:0]               fuse_high_i,
    input  wire [7:0]               fuse_ext_i,
    // CPU status
    output reg                      store_ready_irq_o,
    output reg                      cpu_stall_o,
    output reg                      live_section_busy_o,
    output reg  [7:0]               lpm_data_o,
    output reg                      lpm_valid_o,
    // Temporary page buffer
    output reg                      buf_write_o,
    output reg  [PAGE_W-1:0]        buf_word_o,
    output reg  [15:0]              buf_data_o,
    output reg                      buf_discard_o,
    // Flash array
    output reg                      flash_erase_o,
    output reg                      flash_write_o,
    output reg                      lock_write_o,
    output reg  [ADDR_W-PAGE_W-1:0] flash_page_o,
    output reg  [ADDR_W-1:0]        boot_start_o
);
    localparam PG_W = ADDR_W - PAGE_W;
    localparam [PG_W-1:0] STALL_FIRST = (1 << PG_W) - `STALL_PAGES;

    reg              irq_en_reg;
    reg              busy_reg;
    reg              rre_reg;
    reg              lbw_reg;
    reg              pw_reg;
    reg              pe_reg;
    reg              se_reg;
    reg  [2:0]       win_reg;
    reg              op_reg;
    reg              buf_loaded_reg;
    reg  [7:0]       lock_bits_reg;
    reg  [7:0]       lock_data_reg;
    reg  [PG_W-1:0]  boot_pages;
    reg  [PG_W-1:0]  boot_page;
    reg              cmd_valid;
    reg  [7:0]       fuse_sel;

    wire [7:0]       ctrl_read;
    wire             bus_req;
    wire             ctrl_sel;
    wire             wr_fire;
    wire [PG_W-1:0]  page_sel;
    wire             stall_target;
    wire             spm_ok;
    wire             lpm_ok;
    wire             op_start;
    wire             op_done;

    assign ctrl_read = {irq_en_reg, busy_reg, 1'b0, rre_reg, lbw_reg, pw_reg, pe_reg, se_reg};
    assign bus_req   = wb_cyc_i && wb_stb_i;
    assign ctrl_sel  = (wb_adr_i == `CTRL_OFFSET);
    // The write lands on the edge at which the master sees ack.
    assign wr_fire   = bus_req && wb_ack_o && wb_we_i && ctrl_sel && wb_sel_i[0];

    assign page_sel     = pointer_i[ADDR_W:PAGE_W+1];
    assign stall_target = (page_sel >= STALL_FIRST);

    assign spm_ok = spm_exec_i && se_reg && (win_reg != 3'd0) && !op_reg && !eeprom_busy_i;
    assign lpm_ok = lpm_exec_i && se_reg && lbw_reg && !op_reg && !eeprom_busy_i
                    && (win_reg > (`STORE_WINDOW - `LOAD_WINDOW));
    assign op_start = spm_ok && (lbw_reg || pw_reg || pe_reg);

    prog_timer #(
        .CNT_W  (CNT_W),
        .CYCLES (PROG_CYCLES)
    ) op_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .start_i (op_start),
        .busy_o  (),
        .done_o  (op_done)
    );

    always @* begin
        case (wb_dat_i[4:0])
            `CMD_FILL:     cmd_valid = 1'b1;
            `CMD_ERASE:    cmd_valid = 1'b1;
            `CMD_WRITE:    cmd_valid = 1'b1;
            `CMD_LOCK:     cmd_valid = 1'b1;
            `CMD_REENABLE: cmd_valid = 1'b1;
            default:       cmd_valid = 1'b0;
        endcase
        boot_pages = {{(PG_W-3){1'b0}}, 3'd4} << (~boot_size_select_i);
        boot_page  = {PG_W{1'b0}} - boot_pages;
        case (pointer_i[1:0])
            2'd0:    fuse_sel = ~fuse_low_i;
            2'd1:    fuse_sel = lock_bits_reg;
            2'd2:    fuse_sel = ~fuse_ext_i;
            2'd3:    fuse_sel = ~fuse_high_i;
            default: fuse_sel = 8'hff;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o            <= 32'h00000000;
            wb_ack_o            <= 1'b0;
            {irq_en_reg, busy_reg, rre_reg, lbw_reg, pw_reg, pe_reg, se_reg} <= 7'h00;
            win_reg             <= 3'd0;
            op_reg              <= 1'b0;
            buf_loaded_reg      <= 1'b0;
            lock_bits_reg       <= `LOCK_RESET;
            lock_data_reg       <= `LOCK_RESET;
            store_ready_irq_o   <= 1'b0;
            cpu_stall_o         <= 1'b0;
            live_section_busy_o <= 1'b0;
            lpm_data_o          <= 8'h00;
            lpm_valid_o         <= 1'b0;
            buf_write_o         <= 1'b0;
            buf_word_o          <= {PAGE_W{1'b0}};
            buf_data_o          <= 16'h0000;
            buf_discard_o       <= 1'b0;
            flash_erase_o       <= 1'b0;
            flash_write_o       <= 1'b0;
            lock_write_o        <= 1'b0;
            flash_page_o        <= {PG_W{1'b0}};
            boot_start_o        <= {ADDR_W{1'b0}};
        end else if (ce_i) begin
            lpm_valid_o   <= 1'b0;
            buf_write_o   <= 1'b0;
            buf_discard_o <= 1'b0;
            boot_start_o  <= {boot_page, {PAGE_W{1'b0}}};

            // One wait state; unmapped offsets answer with zero.
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                if (ctrl_sel)
                    wb_dat_o <= {24'h000000, ctrl_read};
                else if (wb_adr_i == `LOCK_OFFSET)
                    wb_dat_o <= {24'h000000, lock_bits_reg};
                else
                    wb_dat_o <= 32'h00000000;
            end

            if (wr_fire) begin
                irq_en_reg <= wb_dat_i[`IRQ_EN_BIT];
                if (wb_dat_i[`RRE_BIT] && buf_loaded_reg) begin
                    buf_discard_o  <= 1'b1;
                    buf_loaded_reg <= 1'b0;
                end
                // A store still armed or running makes new commands pointless.
                if (cmd_valid && !se_reg && !eeprom_busy_i) begin
                    rre_reg <= wb_dat_i[`RRE_BIT];
                    lbw_reg <= wb_dat_i[`LBW_BIT];
                    pw_reg  <= wb_dat_i[`PW_BIT];
                    pe_reg  <= wb_dat_i[`PE_BIT];
                    se_reg  <= 1'b1;
                    win_reg <= `STORE_WINDOW;
                end
            end

            if (spm_ok) begin
                win_reg <= 3'd0;
                if (op_start) begin
                    op_reg        <= 1'b1;
                    flash_page_o  <= page_sel;
                    lock_data_reg <= low_data_reg_i;
                    lock_write_o  <= lbw_reg;
                    flash_write_o <= pw_reg;
                    flash_erase_o <= pe_reg;
                    if (pw_reg || pe_reg) begin
                        cpu_stall_o <= stall_target;
                        if (!stall_target)
                            busy_reg <= 1'b1;
                    end
                end else begin
                    se_reg  <= 1'b0;
                    rre_reg <= 1'b0;
                    busy_reg <= 1'b0;
                    if (!rre_reg) begin
                        buf_write_o    <= 1'b1;
                        buf_word_o     <= pointer_i[PAGE_W:1];
                        buf_data_o     <= {high_data_reg_i, low_data_reg_i};
                        buf_loaded_reg <= 1'b1;
                    end
                end
            end else if (lpm_ok) begin
                lpm_data_o  <= fuse_sel;
                lpm_valid_o <= 1'b1;
                se_reg      <= 1'b0;
                lbw_reg     <= 1'b0;
                win_reg     <= 3'd0;
            end else if (win_reg != 3'd0 && !op_reg) begin
                win_reg <= win_reg - 3'd1;
                if (win_reg == 3'd1) begin
                    {rre_reg, lbw_reg, pw_reg, pe_reg, se_reg} <= 5'h00;
                end
            end

            if (op_done) begin
                if (lock_write_o)
                    lock_bits_reg <= lock_bits_reg & (lock_data_reg | `LOCK_UNUSED_MASK);
                if (flash_write_o)
                    buf_loaded_reg <= 1'b0;
                op_reg        <= 1'b0;
                cpu_stall_o   <= 1'b0;
                lock_write_o  <= 1'b0;
                flash_write_o <= 1'b0;
                flash_erase_o <= 1'b0;
                {lbw_reg, pw_reg, pe_reg, se_reg} <= 4'h0;
            end

            live_section_busy_o <= busy_reg;
            store_ready_irq_o <= irq_en_reg && global_irq_enable_i && !se_reg;
        end
    end
endmodule

/* core/flash_spm_consts.vh */
// Purpose: Shared constants for the flash self-programming control block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, 10 MHz clock.
// Notes:   Timing counts are derived from the printed times and the clock period.
`ifndef FLASH_SPM_CONSTS_VH
`define FLASH_SPM_CONSTS_VH

// Register byte offsets.
`define CTRL_OFFSET        4'h0
`define LOCK_OFFSET        4'h4

// Control and status field positions.
`define IRQ_EN_BIT         7
`define BUSY_BIT           6
`define RRE_BIT            4
`define LBW_BIT            3
`define PW_BIT             2
`define PE_BIT             1
`define SE_BIT             0

// Reset values.
`define CTRL_RESET         8'h00
`define LOCK_RESET         8'hff
`define LOCK_UNUSED_MASK   8'hc0

// Accepted low five-bit command codes.
`define CMD_FILL           5'h01
`define CMD_ERASE          5'h03
`define CMD_WRITE          5'h05
`define CMD_LOCK           5'h09
`define CMD_REENABLE       5'h11

// Stalling section size in pages, counted down from the top of flash.
`define STALL_PAGES        32

// Arming windows in cycles.
`define STORE_WINDOW       3'd4
`define LOAD_WINDOW        3'd3

// Flash operation timing.
`define CLK_PERIOD_NS      100
`define PROG_MIN_NS        3700000
`define PROG_MAX_NS        4500000
`define PROG_MIN_CYCLES    ((`PROG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MAX_CYCLES    (`PROG_MAX_NS / `CLK_PERIOD_NS)

`endif

/* core/prog_timer.v */
// Purpose: Times one flash erase, page write or lock write.
// Assumes: Start is a one-cycle pulse while idle.
// Notes:   Done pulses once when the count has run out.
`timescale 1ns/1ps
module prog_timer #(
    parameter CNT_W  = 16,
    parameter CYCLES = 37000
) (
    // Clock and control
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             ce_i,
    input  wire             start_i,
    // Status
    output reg              busy_o,
    output reg              done_o
);
    localparam [CNT_W-1:0] LAST = CYCLES - 1;

    reg [CNT_W-1:0] count_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= {CNT_W{1'b0}};
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                count_reg <= {CNT_W{1'b0}};
                busy_o    <= 1'b1;
            end else if (busy_o) begin
                if (count_reg == LAST) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end
endmodule

/* test/cpu_core_model.sv */
// Purpose: CPU core issuing store and load program instructions.
// Assumes: One instruction strobe lasts one clock cycle.
// Notes:   Released data lines show inverted values so stale capture shows.
`timescale 1ns/1ps
module cpu_core_model (
    // Clock
    input  wire logic  clk_i,
    // Instruction side
    output logic        spm_exec_o,
    output logic        lpm_exec_o,
    output logic [15:0] pointer_o,
    output logic [7:0]  low_data_reg_o,
    output logic [7:0]  high_data_reg_o
);
    initial begin
        spm_exec_o = 1'b0;
        lpm_exec_o = 1'b0;
        pointer_o = 16'h0000;
        low_data_reg_o = 8'h00;
        high_data_reg_o = 8'h00;
    end
    task store(input logic [15:0] ptr, input logic [7:0] hi, input logic [7:0] lo, input int dly);
        repeat (dly) @(posedge clk_i);
        spm_exec_o <= 1'b1;
        pointer_o <= {ptr[15:1], 1'b0};
        high_data_reg_o <= hi;
        low_data_reg_o <= lo;
        @(posedge clk_i);
        spm_exec_o <= 1'b0;
        pointer_o <= ~{ptr[15:1], 1'b0};
        high_data_reg_o <= ~hi;
        low_data_reg_o <= ~lo;
    endtask
    task load(input logic [15:0] ptr, input int dly);
        repeat (dly) @(posedge clk_i);
        lpm_exec_o <= 1'b1;
        pointer_o <= ptr;
        @(posedge clk_i);
        lpm_exec_o <= 1'b0;
        pointer_o <= ~ptr;
    endtask
endmodule

/* test/flash_self_program_control_bench.sv */
// Purpose: Register and instruction sequences for the self-programming control.
// Assumes: Short operation count so each erase or write takes a few cycles.
// Notes:   Clock enable drops once, while a fill is armed, to show the window freezes.
`timescale 1ns/1ps
module flash_self_program_control_bench;
    localparam PROG = 20;
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, global_irq_enable_i;
    logic eeprom_busy_i, spm_exec_i, lpm_exec_i, store_ready_irq_o, cpu_stall_o, lpm_valid_o;
    logic live_section_busy_o, buf_write_o, buf_discard_o, flash_erase_o, flash_write_o;
    logic lock_write_o;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] pointer_i, buf_data_o;
    logic [7:0]  low_data_reg_i, high_data_reg_i, fuse_low_i, fuse_high_i, fuse_ext_i;
    logic [7:0]  lpm_data_o, flash_page_o, lpm_last, q, bad [5], fx [4];
    logic [1:0]  boot_size_select_i;
    logic [5:0]  buf_word_o;
    logic [13:0] boot_start_o;
    int err_total, n_compared, n_fill, n_disc, i, f;
    flash_self_program_control #(.PROG_CYCLES(PROG)) flash_self_program_control_inst (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .spm_exec_i, .lpm_exec_i, .pointer_i, .low_data_reg_i,
        .high_data_reg_i, .global_irq_enable_i, .eeprom_busy_i, .boot_size_select_i, .fuse_low_i,
        .fuse_high_i, .fuse_ext_i, .store_ready_irq_o, .cpu_stall_o, .live_section_busy_o,
        .lpm_data_o, .lpm_valid_o, .buf_write_o, .buf_word_o, .buf_data_o, .buf_discard_o,
        .flash_erase_o, .flash_write_o, .lock_write_o, .flash_page_o, .boot_start_o);
    cpu_core_model cpu_core_model_inst (.clk_i, .spm_exec_o(spm_exec_i), .lpm_exec_o(lpm_exec_i),
        .pointer_o(pointer_i), .low_data_reg_o(low_data_reg_i), .high_data_reg_o(high_data_reg_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_fill <= n_fill + int'(buf_write_o);
        n_disc <= n_disc + int'(buf_discard_o);
        if (lpm_valid_o) lpm_last <= lpm_data_o;
    end
    task stop_test;
        $display("mismatches %0d, comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            stop_test;
        end
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk({8'h00, q}, {8'h00, e});
    endtask
    task op_wait;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((flash_erase_o | flash_write_o | lock_write_o) !== 1'b0 && n < 200);
        repeat (3) @(posedge clk_i);
    endtask
    task erase_live;
        wr(4'h0, 8'h03);
        cpu_core_model_inst.store(16'h0280, 8'h00, 8'h00, 0);
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        #(100 * 20000);
        err_total++;
        stop_test;
    end
    initial begin
        {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
        {wb_adr_i, wb_sel_i, wb_dat_i, global_irq_enable_i, eeprom_busy_i} = '0;
        n_fill = 0;
        n_disc = 0;
        err_total = 0;
        n_compared = 0;
        boot_size_select_i = 2'b00;
        fuse_low_i = 8'h62;
        fuse_high_i = 8'h19;
        fuse_ext_i = 8'h05;
        bad = '{8'h07, 8'h1f, 8'h02, 8'h10, 8'h0c};
        fx = '{8'h9d, 8'hf0, 8'hfa, 8'he6};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'hff);
        rd(4'h8, 8'h00);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'hff);
        for (i = 0; i < 5; i++) begin
            wr(4'h0, bad[i]);
            rd(4'h0, 8'h00);
        end
        for (i = 0; i < 2; i++) begin
            wr(4'h0, 8'h01);
            cpu_core_model_inst.store(16'h0047, 8'ha5, 8'h3c, i * 3);
            repeat (3) @(posedge clk_i);
            chk(16'(n_fill), 16'(i + 1));
            chk({10'h000, buf_word_o}, 16'h0023);
            rd(4'h0, 8'h00);
        end
        wr(4'h0, 8'h01);
        cpu_core_model_inst.store(16'h0002, 8'h11, 8'h22, 5);
        repeat (3) @(posedge clk_i);
        chk(16'(n_fill), 16'd2);
        wr(4'h0, 8'h01);
        ce_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        ce_i <= 1'b1;
        cpu_core_model_inst.store(16'h0004, 8'h5a, 8'hc3, 0);
        repeat (3) @(posedge clk_i);
        chk(16'(n_fill), 16'd3);
        chk(buf_data_o, 16'h5ac3);
        wr(4'h0, 8'h11);
        repeat (2) @(posedge clk_i);
        chk(16'(n_disc), 16'd1);
        repeat (4) @(posedge clk_i);
        erase_live;
        chk({15'h0, live_section_busy_o}, 16'h1);
        chk({8'h00, flash_page_o}, 16'h0005);
        rd(4'h0, 8'h43);
        op_wait;
        rd(4'h0, 8'h40);
        wr(4'h0, 8'h11);
        cpu_core_model_inst.store(16'h0000, 8'h00, 8'h00, 1);
        repeat (3) @(posedge clk_i);
        chk({15'h0, live_section_busy_o}, 16'h0);
        wr(4'h0, 8'h05);
        cpu_core_model_inst.store(16'h7d00, 8'h00, 8'h00, 0);
        repeat (3) @(posedge clk_i);
        chk({13'h0, flash_write_o, cpu_stall_o, live_section_busy_o}, 16'h6);
        chk({8'h00, flash_page_o}, 16'h00fa);
        op_wait;
        chk({15'h0, cpu_stall_o}, 16'h0);
        erase_live;
        op_wait;
        wr(4'h0, 8'h01);
        cpu_core_model_inst.store(16'h0002, 8'h01, 8'h02, 0);
        repeat (3) @(posedge clk_i);
        chk({15'h0, live_section_busy_o}, 16'h0);
        wr(4'h0, 8'h09);
        cpu_core_model_inst.store(16'h0000, 8'h00, 8'hf0, 0);
        repeat (3) @(posedge clk_i);
        chk({15'h0, lock_write_o}, 16'h1);
        op_wait;
        rd(4'h4, 8'hf0);
        for (i = 0; i < 4; i++) begin
            wr(4'h0, 8'h09);
            cpu_core_model_inst.load(16'(i), i % 3);
            repeat (3) @(posedge clk_i);
            chk({8'h00, lpm_last}, {8'h00, fx[i]});
        end
        global_irq_enable_i <= 1'b1;
        wr(4'h0, 8'h80);
        repeat (2) @(posedge clk_i);
        chk({15'h0, store_ready_irq_o}, 16'h1);
        wr(4'h0, 8'h81);
        repeat (2) @(posedge clk_i);
        chk({15'h0, store_ready_irq_o}, 16'h0);
        repeat (6) @(posedge clk_i);
        chk({15'h0, store_ready_irq_o}, 16'h1);
        global_irq_enable_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({15'h0, store_ready_irq_o}, 16'h0);
        wr(4'h0, 8'h00);
        f = n_fill;
        eeprom_busy_i <= 1'b1;
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h00);
        eeprom_busy_i <= 1'b0;
        wr(4'h0, 8'h01);
        eeprom_busy_i <= 1'b1;
        cpu_core_model_inst.store(16'h0002, 8'h01, 8'h02, 0);
        repeat (3) @(posedge clk_i);
        chk(16'(n_fill), 16'(f));
        eeprom_busy_i <= 1'b0;
        for (i = 0; i < 4; i++) begin
            boot_size_select_i <= 2'(i);
            repeat (3) @(posedge clk_i);
            chk({2'b00, boot_start_o}, 16'(16384 - (256 << (3 - i))));
        end
        stop_test;
    end
endmodule

/* test/flash_self_program_control_monitor.sv */
// Purpose: Concurrent checks on the self-programming control ports.
// Assumes: Default widths of the control block; ce_i drops only while no operation runs.
// Notes:   Operation length is judged by a small cycle counter.
`timescale 1ns/1ps
module flash_self_program_control_monitor #(
    parameter PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Watched ports
    input wire logic        global_irq_enable_i,
    input wire logic        eeprom_busy_i,
    input wire logic        spm_exec_i,
    input wire logic        lpm_exec_i,
    input wire logic [15:0] pointer_i,
    input wire logic [7:0]  low_data_reg_i,
    input wire logic [7:0]  high_data_reg_i,
    input wire logic [1:0]  boot_size_select_i,
    input wire logic [7:0]  fuse_low_i,
    input wire logic [7:0]  fuse_high_i,
    input wire logic        store_ready_irq_o,
    input wire logic        cpu_stall_o,
    input wire logic        live_section_busy_o,
    input wire logic [7:0]  lpm_data_o,
    input wire logic        lpm_valid_o,
    input wire logic        buf_write_o,
    input wire logic [5:0]  buf_word_o,
    input wire logic [15:0] buf_data_o,
    input wire logic        flash_erase_o,
    input wire logic        flash_write_o,
    input wire logic        lock_write_o,
    input wire logic [7:0]  flash_page_o,
    input wire logic [13:0] boot_start_o
);
    int  op_len;
    wire op_on = flash_erase_o | flash_write_o | lock_write_o;
    always @(posedge clk_i) begin
        op_len <= (rst_i || !op_on) ? 0 : op_len + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_irq_gate;
        store_ready_irq_o |-> $past(global_irq_enable_i);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("ready request while masked");
    property p_stall_page;
        cpu_stall_o |-> flash_page_o >= 8'd224;
    endproperty
    a_stall_page: assert property (p_stall_page) else $error("stall outside top pages");
    property p_busy_rise;
        $rose(live_section_busy_o) |-> (flash_erase_o || flash_write_o) && flash_page_o < 8'd224;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy set without live operation");
    property p_busy_fall;
        $fell(live_section_busy_o) |-> !flash_erase_o && !flash_write_o;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy cleared during operation");
    property p_fill;
        buf_write_o |-> $past(spm_exec_i) && !$past(eeprom_busy_i) && buf_word_o == $past(pointer_i[6:1])
            && buf_data_o == {$past(high_data_reg_i), $past(low_data_reg_i)};
    endproperty
    a_fill: assert property (p_fill) else $error("buffer word mismatch");
    property p_fuse_read;
        lpm_valid_o |-> $past(lpm_exec_i) && ($past(pointer_i[1:0]) != 2'd0 || lpm_data_o == ~$past(fuse_low_i))
            && ($past(pointer_i[1:0]) != 2'd3 || lpm_data_o == ~$past(fuse_high_i));
    endproperty
    a_fuse_read: assert property (p_fuse_read) else $error("fuse byte mismatch");
    property p_op_len;
        $fell(op_on) |-> op_len >= PROG_CYCLES && op_len <= PROG_CYCLES + 2;
    endproperty
    a_op_len: assert property (p_op_len) else $error("operation length wrong");
    property p_boot_start;
        !$past(rst_i) |-> int'(boot_start_o) == 16384 - (256 << (3 - int'($past(boot_size_select_i))));
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("boot start wrong");
endmodule
bind flash_self_program_control flash_self_program_control_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
    .clk_i, .rst_i, .global_irq_enable_i, .eeprom_busy_i, .spm_exec_i, .lpm_exec_i, .pointer_i,
    .low_data_reg_i, .high_data_reg_i, .boot_size_select_i, .fuse_low_i, .fuse_high_i,
    .store_ready_irq_o, .cpu_stall_o, .live_section_busy_o, .lpm_data_o, .lpm_valid_o,
    .buf_write_o, .buf_word_o, .buf_data_o, .flash_erase_o, .flash_write_o, .lock_write_o,
    .flash_page_o, .boot_start_o);
